// >>> rx_desc_wb_cfg.svh
`ifndef RX_DESC_WB_CFG_SVH
`define RX_DESC_WB_CFG_SVH

// Register offsets on the plain register port
`define A_CTRL      8'h00
`define A_HEAD      8'h04
`define A_TEARDOWN  8'h08
`define A_STATUS    8'h0C

`define CTRL_RST    32'h00000000

// Control register fields
`define C_RUN       0
`define C_ERR_COPY  1
`define C_SHORT_COPY 2
`define C_CTL_COPY  3
`define C_ALL_COPY  4

// Descriptor word indices
`define W_NEXT      2'h0
`define W_BUF       2'h1
`define W_OFFLEN    2'h2
`define W_FLAGLEN   2'h3

// Flag masks of the fourth descriptor word
`define FLAG_PKT_START 32'h80000000
`define FLAG_PKT_END   32'h40000000
`define FLAG_OWNERSHIP_FLAG     32'h20000000
`define FLAG_QUEUE_END 32'h10000000
`define FLAG_TDOWN     32'h08000000
`define FLAG_CRC_PASS  32'h04000000
`define FLAG_JABBER    32'h02000000
`define FLAG_OVERSIZE  32'h01000000
`define FLAG_FRAGMENT  32'h00800000
`define FLAG_UNDERSIZE 32'h00400000
`define FLAG_CONTROL   32'h00200000
`define FLAG_OVERRUN   32'h00100000
`define FLAG_SYMBOL    32'h00080000
`define FLAG_ALIGN     32'h00040000
`define FLAG_FCS       32'h00020000
`define FLAG_UNMATCHED 32'h00010000

`endif

// >>> rx_desc_wb_pkg.sv
package rx_desc_wb_pkg;

  typedef enum logic [9:0] {
    S_HALT     = 10'b0000000001,
    S_IDLE     = 10'b0000000010,
    S_LOAD     = 10'b0000000100,
    S_FILL     = 10'b0000001000,
    S_WB_LEN   = 10'b0000010000,
    S_DROP     = 10'b0000100000,
    S_WB_LAST  = 10'b0001000000,
    S_WB_FIRST = 10'b0010000000,
    S_TD_WR    = 10'b0100000000,
    S_STOP     = 10'b1000000000
  } state_t;

  typedef struct packed {
    logic jabber;
    logic oversize;
    logic fragment;
    logic undersize;
    logic control;
    logic overrun;
    logic symbol_fault;
    logic alignment_fault;
    logic fcs_fault;
    logic unmatched;
    logic has_fcs;
  } frame_status_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_only;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;

endpackage

// >>> rx_desc_wb.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "rx_desc_wb_cfg.svh"
module rx_desc_wb (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [31:0]                         reg_rdata,
  output rx_desc_wb_pkg::mem_cmd_t            mem_cmd,
  input  wire logic                           mem_ready,
  input  wire logic [31:0]                    mem_rdata,
  input  wire logic                           rx_valid,
  input  wire logic [7:0]                     rx_data,
  input  wire logic                           rx_last,
  input  wire rx_desc_wb_pkg::frame_status_t  rx_status,
  output logic                                rx_ready
);
  import rx_desc_wb_pkg::*;

  function automatic logic [31:0] word_addr(input logic [31:0] base,
                                            input logic [1:0]  idx);
    word_addr = base + {28'h0, idx, 2'h0};
  endfunction

  function automatic logic [31:0] flag(input logic c, input logic [31:0] m);
    flag = c ? m : 32'h0;
  endfunction

  state_t        state;
  state_t        next_state;
  logic [31:0]   ctrl;
  logic          td_req;
  logic          td_done;
  logic          td_mode;
  logic [31:0]   cur;
  logic [31:0]   nxt;
  logic [31:0]   bptr;
  logic [15:0]   blen;
  logic [31:0]   w3;
  logic [31:0]   first_addr;
  logic [31:0]   first_w3;
  logic          is_first;
  logic [15:0]   off;
  logic [15:0]   cnt;
  logic [15:0]   plen;
  logic [1:0]    widx;
  logic          rd_pend;
  logic          ended;
  frame_status_t fst;

  wire [15:0] rx_offset_config          = ctrl[31:16];
  wire        run_en                    = ctrl[`C_RUN];
  wire        error_frame_copy_enable   = ctrl[`C_ERR_COPY];
  wire        short_frame_copy_enable   = ctrl[`C_SHORT_COPY];
  wire        control_frame_copy_enable = ctrl[`C_CTL_COPY];
  wire        copy_all_enable           = ctrl[`C_ALL_COPY];

  wire wr_ctrl = reg_wr && (reg_addr == `A_CTRL);
  wire wr_head = reg_wr && (reg_addr == `A_HEAD);
  wire wr_td   = reg_wr && (reg_addr == `A_TEARDOWN);

  wire take     = rx_valid && rx_ready;
  wire mem_go   = mem_cmd.req && mem_ready;
  wire last_rd  = (state == S_LOAD) && rd_pend && (widx == `W_FLAGLEN);
  wire null_nxt = (nxt == 32'h0);
  wire idle_go  = td_req || (run_en && rx_valid);
  // Buffer length from software sizes the room left after the offset
  wire room_hit = (cnt + 16'h1) == (blen - off);
  wire td_fin   = ((state == S_TD_WR) && mem_ready) ||
                  ((state == S_HALT) && td_req);

  assign rx_ready = ((state == S_FILL) && mem_ready) || (state == S_DROP);

  // Word 2: offset only in the first buffer, length = bytes written
  wire [31:0] len_word = {is_first ? off : 16'h0, cnt};
  // Software left the end and queue-end bits clear, so OR is enough
  wire [31:0] last_word = w3 | `FLAG_PKT_END
                        | flag(null_nxt, `FLAG_QUEUE_END);
  wire [31:0] td_word  = w3 | `FLAG_TDOWN;
  wire [31:0] err_bits =
      flag(fst.jabber && error_frame_copy_enable, `FLAG_JABBER)
    | flag(fst.oversize && error_frame_copy_enable, `FLAG_OVERSIZE)
    | flag(fst.fragment && error_frame_copy_enable, `FLAG_FRAGMENT)
    | flag(fst.symbol_fault && error_frame_copy_enable, `FLAG_SYMBOL)
    | flag(fst.alignment_fault && error_frame_copy_enable, `FLAG_ALIGN)
    | flag(fst.fcs_fault && error_frame_copy_enable, `FLAG_FCS)
    | flag(fst.undersize && short_frame_copy_enable, `FLAG_UNDERSIZE)
    | flag(fst.control && control_frame_copy_enable, `FLAG_CONTROL)
    | flag(fst.overrun, `FLAG_OVERRUN)
    | flag(fst.unmatched && copy_all_enable, `FLAG_UNMATCHED)
    | flag(fst.has_fcs, `FLAG_CRC_PASS);
  // First descriptor, written last with ownership dropped
  wire [31:0] first_word = (first_w3 & ~`FLAG_OWNERSHIP_FLAG & 32'hFFFF0000)
                         | `FLAG_PKT_START
                         | flag(is_first, `FLAG_PKT_END)
                         | flag(is_first && null_nxt, `FLAG_QUEUE_END)
                         | err_bits
                         | {16'h0, plen};

  wire m_req = ((state == S_LOAD) && !rd_pend)
            || ((state == S_FILL) && rx_valid)
            || (state == S_WB_LEN) || (state == S_WB_LAST)
            || (state == S_WB_FIRST) || (state == S_TD_WR);
  wire m_we  = (state != S_LOAD);
  wire [31:0] m_addr =
      (state == S_LOAD)   ? word_addr(cur, widx) :
      (state == S_FILL)   ? bptr + {16'h0, off} + {16'h0, cnt} :
      (state == S_WB_LEN) ? word_addr(cur, `W_OFFLEN) :
      (state == S_WB_FIRST) ? word_addr(first_addr, `W_FLAGLEN) :
                            word_addr(cur, `W_FLAGLEN);
  wire [31:0] m_wdata =
      (state == S_FILL)   ? {24'h0, rx_data} :
      (state == S_WB_LEN) ? len_word :
      (state == S_WB_LAST) ? last_word :
      (state == S_TD_WR)  ? td_word : first_word;

  assign mem_cmd = {m_req, m_we, state == S_FILL, m_addr, m_wdata};

  always_comb begin
    next_state = state;
    unique case (state)
      S_HALT: begin
        if (td_req) next_state = S_STOP;
        else if (wr_head) next_state = S_IDLE;
      end
      S_STOP: begin
        if (wr_head) next_state = S_IDLE;
      end
      S_IDLE: begin
        if (idle_go) next_state = S_LOAD;
      end
      S_LOAD: begin
        if (last_rd) next_state = td_mode ? S_TD_WR : S_FILL;
      end
      S_FILL: begin
        if (take && (rx_last || room_hit)) next_state = S_WB_LEN;
      end
      S_WB_LEN: begin
        // Lengths go out before the first descriptor is released
        if (mem_ready) begin
          if (ended) next_state = is_first ? S_WB_FIRST : S_WB_LAST;
          else next_state = null_nxt ? S_DROP : S_LOAD;
        end
      end
      S_DROP: begin
        if (take && rx_last) next_state = is_first ? S_WB_FIRST : S_WB_LAST;
      end
      S_WB_LAST: begin
        if (mem_ready) next_state = S_WB_FIRST;
      end
      S_WB_FIRST: begin
        if (mem_ready) next_state = null_nxt ? S_HALT : S_IDLE;
      end
      S_TD_WR: begin
        if (mem_ready) next_state = S_STOP;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) state <= S_HALT;
    else state <= next_state;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl    <= `CTRL_RST;
      td_req  <= 1'b0;
      td_done <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata;
      td_req  <= wr_td || (td_req && !td_fin);
      td_done <= td_fin || (td_done && !wr_head);
    end
  end

  // Descriptor fetch: one read in flight, data one cycle after acceptance
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_pend <= 1'b0;
      widx    <= `W_NEXT;
      nxt     <= 32'h0;
      bptr    <= 32'h0;
      blen    <= 16'h0;
      w3      <= 32'h0;
      first_w3 <= 32'h0;
    end else if (state == S_LOAD) begin
      rd_pend <= mem_go;
      if (rd_pend) begin
        widx <= widx + 2'h1;
        unique case (widx)
          `W_NEXT:   nxt  <= mem_rdata;
          `W_BUF:    bptr <= mem_rdata;
          `W_OFFLEN: blen <= mem_rdata[15:0];
          `W_FLAGLEN: begin
            w3 <= mem_rdata;
            if (is_first) first_w3 <= mem_rdata;
          end
        endcase
      end
    end else begin
      widx <= `W_NEXT;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur      <= 32'h0;
      first_addr <= 32'h0;
      is_first   <= 1'b0;
      td_mode  <= 1'b0;
      off      <= 16'h0;
      cnt      <= 16'h0;
      plen     <= 16'h0;
      ended    <= 1'b0;
      fst      <= '0;
    end else begin
      if ((state == S_HALT || state == S_STOP) && wr_head)
        cur <= {reg_wdata[31:2], 2'h0};
      if (state == S_IDLE && idle_go) begin
        is_first   <= 1'b1;
        first_addr <= cur;
        td_mode  <= td_req;
        plen     <= 16'h0;
        ended    <= 1'b0;
        fst      <= '0;
      end
      if (last_rd) begin
        off <= is_first ? rx_offset_config : 16'h0;
        cnt <= 16'h0;
      end
      if (state == S_FILL && take) begin
        cnt  <= cnt + 16'h1;
        plen <= plen + 16'h1;
        if (rx_last) begin
          ended <= 1'b1;
          fst   <= rx_status;
        end
      end
      if (state == S_WB_LEN && mem_ready && !ended && !null_nxt) begin
        cur    <= nxt;
        is_first <= 1'b0;
      end
      // Queue ran dry mid-frame: rest is discarded, frame marked overrun
      if (state == S_DROP && take && rx_last) begin
        fst         <= rx_status;
        fst.overrun <= 1'b1;
      end
      if (state == S_WB_FIRST && mem_ready && !null_nxt) cur <= nxt;
    end
  end

  wire stopped = (state == S_HALT) || (state == S_STOP);
  wire [31:0] status_word = {28'h0, td_done, state == S_STOP,
                             state == S_HALT, !stopped && state != S_IDLE};
  wire [31:0] rd_mux = (reg_addr == `A_CTRL)   ? ctrl :
                       (reg_addr == `A_HEAD)   ? cur :
                       (reg_addr == `A_STATUS) ? status_word : 32'h0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ownership_flag_release: assert property (
    (state == S_WB_FIRST && m_req)
      |-> !m_wdata[29] && m_addr == word_addr(first_addr, `W_FLAGLEN))
    else $error("ownership not cleared in first descriptor");

  a_release_last: assert property (
    (state == S_WB_FIRST && $changed(state))
      |-> $past(state) inside {S_WB_LEN, S_WB_LAST, S_DROP})
    else $error("release before length write-back");

  a_offset_first: assert property (
    (state == S_WB_LEN && !is_first) |-> m_wdata[31:16] == 16'h0)
    else $error("offset recorded outside first buffer");

  a_offset_used: assert property (
    (last_rd && is_first && !td_mode) |=> off == $past(rx_offset_config))
    else $error("receive offset not applied");

  a_len_count: assert property (
    (state == S_FILL && take && rx_last)
      |=> state == S_WB_LEN && m_wdata[15:0] == $past(cnt) + 16'h1)
    else $error("buffer length differs from bytes written");

  a_queue_end: assert property (
    (state == S_WB_FIRST && mem_ready && null_nxt) |=> state == S_HALT)
    else $error("channel not halted at queue end");

  a_td_stop: assert property (
    (state == S_TD_WR && mem_ready) |-> m_wdata[27] ##1 state == S_STOP)
    else $error("teardown did not stop queue");

  a_pkt_len: assert property (
    (state == S_WB_FIRST) |-> m_wdata[15:0] == plen && m_wdata[31])
    else $error("packet length or start flag wrong");

  a_overrun_flag: assert property (
    (state == S_WB_FIRST && fst.overrun) |-> m_wdata[20])
    else $error("overrun not flagged");

  a_end_marks: assert property (
    (state == S_WB_LAST && m_req) |-> m_wdata[30])
    else $error("end flag missing on last buffer");

  a_queue_flag: assert property (
    (state == S_WB_FIRST && is_first && null_nxt) |-> m_wdata[28])
    else $error("queue-end flag missing");

  a_drop_overrun: assert property (
    (state == S_DROP && take && rx_last) |=> fst.overrun)
    else $error("aborted frame not marked overrun");

  a_halt_quiet: assert property (
    (state == S_HALT || state == S_STOP) |-> !mem_cmd.req && !rx_ready)
    else $error("halted channel still active");

endmodule

// >>> rx_mem_model.sv
`timescale 1ns/1ps
module rx_mem_model (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire rx_desc_wb_pkg::mem_cmd_t mem_cmd,
  input  wire logic                     slow,
  output logic                          mem_ready,
  output logic [31:0]                   mem_rdata
);
  import rx_desc_wb_pkg::*;
  logic [31:0] mem [0:255];
  logic [31:0] rd_word;
  logic        rd_valid;
  logic [1:0]  stall_cnt;
  wire         taken    = mem_cmd.req && mem_ready;
  wire  [7:0]  word_sel = mem_cmd.addr[9:2];
  wire  [4:0]  lane     = {mem_cmd.addr[1:0], 3'b000};

  // Slow mode accepts one request in four cycles
  assign mem_ready = !slow || (stall_cnt == 2'h3);
  // Outside the answer cycle the bus shows a different value
  assign mem_rdata = rd_valid ? rd_word : ~rd_word;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stall_cnt <= 2'h0;
      rd_valid  <= 1'b0;
      rd_word   <= 32'h00000000;
    end else begin
      stall_cnt <= stall_cnt + 2'h1;
      rd_valid  <= taken && !mem_cmd.we;
      if (taken && !mem_cmd.we) begin
        rd_word <= mem[word_sel];
      end
    end
  end

  // Descriptor words and buffer bytes shared with the software side
  always @(posedge ref_clk) begin
    if (taken && mem_cmd.we && mem_cmd.byte_only) begin
      mem[word_sel][lane +: 8] <= mem_cmd.wdata[7:0];
    end else if (taken && mem_cmd.we) begin
      mem[word_sel] <= mem_cmd.wdata;
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`include "rx_desc_wb_cfg.svh"
module testbench;
  import rx_desc_wb_pkg::*;
  logic          ref_clk;
  logic          rst;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [31:0]   reg_rdata;
  mem_cmd_t      mem_cmd;
  logic          mem_ready;
  logic [31:0]   mem_rdata;
  logic          rx_valid;
  logic [7:0]    rx_data;
  logic          rx_last;
  frame_status_t rx_status;
  logic          rx_ready;
  logic          slow;
  logic [31:0]   rdv;
  int            miscompares;
  int            tests_run;

  rx_desc_wb dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_cmd(mem_cmd), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_status(rx_status), .rx_ready(rx_ready));

  rx_mem_model host (.ref_clk(ref_clk), .rst(rst), .mem_cmd(mem_cmd),
    .slow(slow), .mem_ready(mem_ready), .mem_rdata(mem_rdata));

  always #50 ref_clk = ~ref_clk;

  task automatic end_sim;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rdv = reg_rdata;
  endtask

  task automatic set_desc(input int i, input logic [31:0] nxt, bptr,
                          input logic [15:0] len);
    host.mem[i*4]   = nxt;
    host.mem[i*4+1] = bptr;
    host.mem[i*4+2] = {16'h0000, len};
    host.mem[i*4+3] = `FLAG_OWNERSHIP_FLAG;
  endtask

  task automatic send(input int n, input logic [7:0] base,
                      input frame_status_t st);
    bit taken;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rx_valid  <= 1'b1;
      rx_data   <= base + 8'(i);
      rx_last   <= (i == n - 1);
      rx_status <= st;
      taken = 1'b0;
      for (int k = 0; k < 200 && !taken; k++) begin
        @(negedge ref_clk);
        taken = rx_ready;
        @(posedge ref_clk);
      end
      if (!taken) begin
        miscompares++;
        end_sim;
      end
    end
    rx_valid <= 1'b0;
  endtask

  // Poll a descriptor bit until it reaches the wanted level
  task automatic wait_bit(input int w, input int b, input logic v);
    int k;
    k = 0;
    while (host.mem[w][b] !== v && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 2000) begin
      miscompares++;
      end_sim;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_status = frame_status_t'(11'h000);
    slow = 1'b0;
    miscompares = 0;
    tests_run = 0;
    set_desc(0, 32'h00000010, 32'h00000100, 16'h0010);
    set_desc(1, 32'h00000020, 32'h00000140, 16'h0004);
    set_desc(2, 32'h00000000, 32'h00000180, 16'h0008);
    set_desc(3, 32'h00000000, 32'h000001C0, 16'h0008);
    host.mem[64] = 32'h00000000;
    host.mem[80] = 32'h00000000;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`A_CTRL);
    chk("ctrl reset", `CTRL_RST, rdv);
    rd(8'h10);
    chk("unmapped read", 32'h00000000, rdv);
    // Offset 2, every copy enable on, frame with all status bits
    wr(`A_CTRL, 32'h0002001F);
    wr(`A_HEAD, 32'h00000000);
    send(6, 8'hA0, frame_status_t'(11'h7FF));
    wait_bit(3, 29, 1'b0);
    chk("d0 offlen", 32'h00020006, host.mem[2]);
    chk("d0 flags", 32'hC7FF0006, host.mem[3]);
    chk("d0 flags", 32'hC7FF0006, host.mem[3]);
    chk("b0 head", 32'hA1A00000, host.mem[64]);
    chk("b0 tail", 32'hA5A4A3A2, host.mem[65]);
    // Enables off, two buffers, stalling memory, chain ends
    wr(`A_CTRL, 32'h00020001);
    slow <= 1'b1;
    send(10, 8'hB0, frame_status_t'(11'h7FE));
    wait_bit(7, 29, 1'b0);
    chk("d2 flags", 32'h70000000, host.mem[11]);
    chk("d1 offlen", 32'h00020002, host.mem[6]);
    chk("d1 flags", 32'h8010000A, host.mem[7]);
    chk("d2 offlen", 32'h00000008, host.mem[10]);
    chk("b1 data", 32'hB1B00000, host.mem[80]);
    chk("b2 tail", 32'hB9B8B7B6, host.mem[97]);
    rd(`A_STATUS);
    chk("halted", 32'h00000002, rdv & 32'h00000002);
    slow <= 1'b0;
    // Teardown on a fresh idle queue
    wr(`A_HEAD, 32'h00000030);
    wr(`A_TEARDOWN, 32'h00000001);
    wait_bit(15, 27, 1'b1);
    chk("d3 flags", 32'h28000000, host.mem[15]);
    rd(`A_STATUS);
    chk("stopped", 32'h0000000C, rdv & 32'h0000000C);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_last  <= 1'b1;
    repeat (20) begin
      @(negedge ref_clk);
      chk("rx stalled", 32'h0, {31'h0, rx_ready});
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    // One short buffer, frame overruns it and the chain ends
    set_desc(4, 32'h00000000, 32'h00000200, 16'h0004);
    host.mem[128] = 32'h00000000;
    wr(`A_HEAD, 32'h00000040);
    send(5, 8'hC0, frame_status_t'(11'h000));
    wait_bit(19, 29, 1'b0);
    chk("d4 offlen", 32'h00020002, host.mem[18]);
    chk("d4 flags", 32'hD0100002, host.mem[19]);
    chk("b4 head", 32'hC1C00000, host.mem[128]);
    rd(`A_STATUS);
    chk("drop halted", 32'h00000002, rdv);
    rd(`A_HEAD);
    chk("head kept", 32'h00000040, rdv);
    // Teardown of a halted queue writes no descriptor
    wr(`A_TEARDOWN, 32'h00000001);
    rd(`A_STATUS);
    chk("halt teardown", 32'h0000000C, rdv);
    chk("d4 untouched", 32'hD0100002, host.mem[19]);
    @(negedge ref_clk);
    chk("rdata idle", 32'h00000000, reg_rdata);
    end_sim;
  end
endmodule
